// >>> src/cps_core.sv
// Processor-core end: issues register orders and sleep requests
`timescale 1ns/1ps
module cps_core
	import cps_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       sys_rst_i,
	// User command port
	input  wire logic [1:0] cmd_addr_i,
	input  wire logic [7:0] cmd_wdata_i,
	input  wire logic       cmd_wr_i,
	input  wire logic       cmd_rd_i,
	input  wire logic       cmd_sleep_i,
	output logic [7:0]      cmd_rdata_o,
	output logic            halted_o,
	output logic            woke_o,
	// Link
	cps_if.core             bus
);
	import cps_pkg::*;

	// ************************************************************
	// Registered command issue
	// ************************************************************
	// Software keeps interrupts off and pairs unlock with value within four cycles
	logic [1:0] addr_r, addr_nxt;
	logic [7:0] wdata_r, wdata_nxt;
	logic       wr_r, wr_nxt, rd_r, rd_nxt, slp_r, slp_nxt;

	always_comb begin
		addr_nxt  = cmd_addr_i;
		wdata_nxt = cmd_wdata_i;
		wr_nxt    = cmd_wr_i && !bus.cpu_halted;
		rd_nxt    = cmd_rd_i && !cmd_wr_i && !bus.cpu_halted;
		slp_nxt   = cmd_sleep_i && !bus.cpu_halted;
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			addr_r  <= 2'h0;
			wdata_r <= 8'h00;
			wr_r    <= 1'b0;
			rd_r    <= 1'b0;
			slp_r   <= 1'b0;
		end else begin
			addr_r  <= addr_nxt;
			wdata_r <= wdata_nxt;
			wr_r    <= wr_nxt;
			rd_r    <= rd_nxt;
			slp_r   <= slp_nxt;
		end
	end

	assign bus.addr        = addr_r;
	assign bus.wdata       = wdata_r;
	assign bus.wr          = wr_r;
	assign bus.rd          = rd_r;
	assign bus.sleep_instr = slp_r;
	assign cmd_rdata_o     = bus.rdata;
	assign halted_o        = bus.cpu_halted;
	assign woke_o          = bus.wake_irq;

endmodule : cps_core

// >>> src/cps_ctrl.sv
// Clock prescaler and sleep controller, the device end
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module cps_ctrl
	import cps_pkg::*;
(
	// Clock and reset
	input  wire logic      sys_clk_i,
	input  wire logic      sys_rst_i,
	// Fuses and clock source
	input  wire logic      div8_fuse_i,
	input  wire logic      crystal_sel_i,
	input  wire logic [7:0] startup_cycles_i,
	// Wake sources
	input  wire logic      int_irq_i,
	input  wire logic      ext_irq_i,
	input  wire logic      async_wake_i,
	// Core link
	cps_if.ctrl            bus,
	// Clock enables
	output logic           cpu_clk_en_o,
	output logic           io_clk_en_o,
	output logic           osc_run_o
);
	import cps_pkg::*;

	// ************************************************************
	// Divider and unlock window
	// ************************************************************
	logic [3:0] sel_r, sel_nxt;
	logic       unlock_r, unlock_nxt;
	logic [2:0] win_r, win_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic       tick;
	logic       fuse_pend_r;
	logic       ext_s1_r, ext_s2_r, asy_s1_r, asy_s2_r;
	logic [3:0] eff_sel;

	// Reserved settings fall back to the largest factor
	assign eff_sel = (sel_r > CPS_SEL_MAX) ? CPS_SEL_MAX : sel_r;
	// Count only restarts at zero, so a new setting waits out the old period first
	assign tick = (cnt_r == 8'h00);

	always_comb begin
		cnt_nxt    = tick ? (8'(1 << eff_sel) - 8'h01) : (cnt_r - 8'h01);
		if (eff_sel == CPS_SEL_MAX && tick)
			cnt_nxt = 8'hFF;
		sel_nxt    = sel_r;
		unlock_nxt = unlock_r;
		win_nxt    = win_r;
		if (unlock_r && tick) begin
			win_nxt = win_r - 3'h1;
			if (win_r == 3'h1)
				unlock_nxt = 1'b0;
		end
		if (bus.wr && bus.addr == CPS_ADDR_DIV) begin
			if (bus.wdata == CPS_UNLOCK_WORD) begin
				if (!unlock_r) begin
					unlock_nxt = 1'b1;
					win_nxt    = CPS_UNLOCK_CYCLES;
				end
			end else if (!bus.wdata[CPS_UNLOCK_BIT] && unlock_r) begin
				sel_nxt    = bus.wdata[3:0];
				unlock_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sel_r       <= CPS_SEL_RST_NOFUSE;
			unlock_r    <= 1'b0;
			win_r       <= 3'h0;
			cnt_r       <= 8'h00;
			fuse_pend_r <= 1'b1;
		end else begin
			sel_r       <= fuse_pend_r ? (div8_fuse_i ? CPS_SEL_RST_FUSE : CPS_SEL_RST_NOFUSE) : sel_nxt;
			unlock_r    <= fuse_pend_r ? 1'b0 : unlock_nxt;
			win_r       <= win_nxt;
			cnt_r       <= fuse_pend_r ? 8'h00 : cnt_nxt;
			fuse_pend_r <= 1'b0;
		end
	end

	// ************************************************************
	// Wake pin synchronisers
	// ************************************************************
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			asy_s1_r <= 1'b0;
			asy_s2_r <= 1'b0;
		end else begin
			ext_s1_r <= ext_irq_i;
			ext_s2_r <= ext_s1_r;
			asy_s1_r <= async_wake_i;
			asy_s2_r <= asy_s1_r;
		end
	end

	// ************************************************************
	// Sleep controller
	// ************************************************************
	logic       se_r, se_nxt;
	logic [1:0] sm_r, sm_nxt;
	cps_state_e st_r, st_nxt;
	cps_mode_e  mode_r, mode_nxt;
	logic [7:0] dly_r, dly_nxt;
	logic       wake_r, wake_nxt;
	logic       wake_ev;
	cps_mode_e  req_mode;

	always_comb begin
		case (sm_r)
			2'b00:   req_mode = CPS_MODE_IDLE;
			2'b10:   req_mode = crystal_sel_i ? CPS_MODE_STBY : CPS_MODE_PDWN;
			default: req_mode = CPS_MODE_PDWN;
		endcase
	end

	// Power-down only listens to pins that need no clock
	assign wake_ev = (mode_r == CPS_MODE_IDLE) ? (int_irq_i | ext_s2_r | asy_s2_r) : (ext_s2_r | asy_s2_r);

	always_comb begin
		se_nxt   = se_r;
		sm_nxt   = sm_r;
		st_nxt   = st_r;
		mode_nxt = mode_r;
		dly_nxt  = dly_r;
		wake_nxt = 1'b0;
		if (bus.wr && bus.addr == CPS_ADDR_SLEEP) begin
			se_nxt = bus.wdata[CPS_SE_BIT];
			sm_nxt = {bus.wdata[CPS_SM1_BIT], bus.wdata[CPS_SM0_BIT]};
		end
		case (st_r)
			CPS_ST_RUN: begin
				if (bus.sleep_instr && se_r) begin
					st_nxt   = CPS_ST_SLEEP;
					mode_nxt = req_mode;
				end
			end
			CPS_ST_SLEEP: begin
				if (wake_ev) begin
					st_nxt = CPS_ST_START;
					case (mode_r)
						CPS_MODE_PDWN: dly_nxt = startup_cycles_i;
						CPS_MODE_STBY: dly_nxt = CPS_STANDBY_WAKE;
						default:       dly_nxt = 8'h00;
					endcase
				end
			end
			CPS_ST_START: begin
				if (dly_r == 8'h00) begin
					st_nxt  = CPS_ST_HALT;
					dly_nxt = {5'h00, CPS_WAKE_HALT};
				end else begin
					dly_nxt = dly_r - 8'h01;
				end
			end
			CPS_ST_HALT: begin
				if (dly_r == 8'h01) begin
					st_nxt   = CPS_ST_RUN;
					wake_nxt = 1'b1;
				end
				dly_nxt = dly_r - 8'h01;
			end
			default: st_nxt = CPS_ST_RUN;
		endcase
	end

	// Reset leaves sleep unconditionally; memory contents are outside this block
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			se_r   <= 1'b0;
			sm_r   <= 2'h0;
			st_r   <= CPS_ST_RUN;
			mode_r <= CPS_MODE_IDLE;
			dly_r  <= 8'h00;
			wake_r <= 1'b0;
		end else begin
			se_r   <= se_nxt;
			sm_r   <= sm_nxt;
			st_r   <= st_nxt;
			mode_r <= mode_nxt;
			dly_r  <= dly_nxt;
			wake_r <= wake_nxt;
		end
	end

	// ************************************************************
	// Clock gating and read port
	// ************************************************************
	logic       cpu_en_r, io_en_r, osc_r;
	logic [7:0] rdata_r;

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cpu_en_r <= 1'b0;
			io_en_r  <= 1'b0;
			osc_r    <= 1'b1;
			rdata_r  <= 8'h00;
		end else begin
			cpu_en_r <= tick && (st_nxt == CPS_ST_RUN);
			io_en_r  <= tick && (st_nxt != CPS_ST_SLEEP || mode_nxt == CPS_MODE_IDLE);
			osc_r    <= !(st_nxt == CPS_ST_SLEEP && mode_nxt == CPS_MODE_PDWN);
			if (bus.rd) begin
				case (bus.addr)
					CPS_ADDR_DIV:   rdata_r <= {unlock_r, 3'h0, sel_r};
					CPS_ADDR_SLEEP: rdata_r <= {1'b0, sm_r[1], se_r, sm_r[0], 4'h0};
					CPS_ADDR_STAT:  rdata_r <= {st_r, 2'h0, mode_r};
					default:        rdata_r <= 8'h00;
				endcase
			end else begin
				rdata_r <= 8'h00;
			end
		end
	end

	assign bus.rdata      = rdata_r;
	assign bus.wake_irq   = wake_r;
	assign bus.cpu_halted = (st_r != CPS_ST_RUN);
	assign cpu_clk_en_o   = cpu_en_r;
	assign io_clk_en_o    = io_en_r;
	assign osc_run_o      = osc_r;

endmodule : cps_ctrl

// >>> src/cps_if.sv
// Register and sleep link between the processor core and the clock controller
`timescale 1ns/1ps
interface cps_if;
	logic [1:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       sleep_instr;
	logic       wake_irq;
	logic       cpu_halted;

	modport ctrl (input addr, input wdata, input wr, input rd, output rdata,
		input sleep_instr, output wake_irq, output cpu_halted);
	modport core (output addr, output wdata, output wr, output rd, input rdata,
		output sleep_instr, input wake_irq, input cpu_halted);
endinterface : cps_if

// >>> src/cps_pkg.sv
// Constants and types shared by the clock prescaler and sleep controller ends
package cps_pkg;

	// ************************************************************
	// Register map and fields
	// ************************************************************
	localparam logic [1:0] CPS_ADDR_DIV   = 2'h0;
	localparam logic [1:0] CPS_ADDR_SLEEP = 2'h1;
	localparam logic [1:0] CPS_ADDR_STAT  = 2'h2;
	localparam int         CPS_UNLOCK_BIT = 7;
	localparam int         CPS_SE_BIT     = 5;
	localparam int         CPS_SM1_BIT    = 6;
	localparam int         CPS_SM0_BIT    = 4;
	localparam logic [3:0] CPS_SEL_RST_NOFUSE = 4'h0;
	localparam logic [3:0] CPS_SEL_RST_FUSE   = 4'h3;
	localparam logic [3:0] CPS_SEL_MAX        = 4'h8;
	localparam logic [7:0] CPS_UNLOCK_WORD    = 8'h80;
	localparam logic [2:0] CPS_UNLOCK_CYCLES  = 3'h4;
	localparam logic [2:0] CPS_WAKE_HALT      = 3'h4;
	localparam logic [7:0] CPS_STANDBY_WAKE   = 8'h06;
	localparam logic [7:0] CPS_RESET_TIMEOUT  = 8'h0E;

	// ************************************************************
	// Sleep modes and controller states
	// ************************************************************
	typedef enum logic [1:0] {
		CPS_MODE_IDLE = 2'h0,
		CPS_MODE_PDWN = 2'h1,
		CPS_MODE_STBY = 2'h2
	} cps_mode_e;

	typedef enum logic [3:0] {
		CPS_ST_RUN   = 4'h1,
		CPS_ST_SLEEP = 4'h2,
		CPS_ST_START = 4'h4,
		CPS_ST_HALT  = 4'h8
	} cps_state_e;

endpackage : cps_pkg

// >>> testbench/clock_prescaler_sleep_ctrl_tb.sv
// Self-checking bench joining the core end and the controller end
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_errors++; $display("unexpected %s exp %0h got %0h", n, e, s); end end
module clock_prescaler_sleep_ctrl_tb;
	// ************************************************************
	// Harness
	// ************************************************************
	logic       clk = 1'b0, rst = 1'b1, fuse = 1'b0, xtal = 1'b0;
	logic [2:0] wk = 3'h0;
	logic [1:0] ca = 2'h0;
	logic [7:0] cd = 8'h00, rdat;
	logic       cw = 1'b0, cr = 1'b0, cs = 1'b0, halted, woke, cen, ien, osc;
	int         n_errors = 0, comparisons = 0;
	always #5 clk = ~clk;
	cps_if link ();
	cps_ctrl cps_ctrl_inst (.sys_clk_i(clk), .sys_rst_i(rst), .div8_fuse_i(fuse), .crystal_sel_i(xtal),
		.startup_cycles_i(8'h14), .int_irq_i(wk[0]), .ext_irq_i(wk[1]), .async_wake_i(wk[2]), .bus(link.ctrl),
		.cpu_clk_en_o(cen), .io_clk_en_o(ien), .osc_run_o(osc));
	cps_core cps_core_inst (.sys_clk_i(clk), .sys_rst_i(rst), .cmd_addr_i(ca), .cmd_wdata_i(cd), .cmd_wr_i(cw),
		.cmd_rd_i(cr), .cmd_sleep_i(cs), .cmd_rdata_o(rdat), .halted_o(halted), .woke_o(woke), .bus(link.core));
	cps_assertions cps_assertions_inst (.sys_clk_i(clk), .sys_rst_i(rst), .addr(link.addr), .wdata(link.wdata),
		.wr(link.wr), .rd(link.rd), .rdata(link.rdata), .sleep_instr(link.sleep_instr),
		.wake_irq(link.wake_irq), .cpu_halted(link.cpu_halted));
	// ************************************************************
	// Link tasks; two writes back to back keep the unlock window short
	// ************************************************************
	task automatic w(input logic [1:0] a, input logic [7:0] d0, input logic [7:0] d1);
		ca <= a;
		cd <= d0;
		cw <= 1'b1;
		@(posedge clk);
		cd <= d1;
		@(posedge clk);
		cw <= 1'b0;
		@(posedge clk);
	endtask : w
	task automatic rd_chk(input logic [1:0] a, input logic [7:0] e, input string n);
		ca <= a;
		cr <= 1'b1;
		@(posedge clk);
		cr <= 1'b0;
		@(posedge clk);
		#1;
		`CHK(n, e, rdat)
		@(posedge clk);
	endtask : rd_chk
	task automatic nap;
		cs <= 1'b1;
		@(posedge clk);
		cs <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : nap
	task automatic cnt(output int nc, output int ni, input int len);
		nc = 0;
		ni = 0;
		repeat (len) begin
			@(negedge clk);
			nc += cen;
			ni += ien;
		end
		@(posedge clk);
	endtask : cnt
	task automatic end_sim;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_rst(input logic f, input logic [7:0] e);
		rst <= 1'b1;
		fuse <= f;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK("halted", 1'b0, halted)
		rd_chk(2'h0, e, "div reset");
		rd_chk(2'h1, 8'h00, "sleep reset");
	endtask : t_rst
	task automatic t_unlock;
		w(2'h0, 8'h80, 8'h80);
		rd_chk(2'h0, 8'h80, "unlock held");
		rd_chk(2'h0, 8'h00, "unlock expired");
		w(2'h0, 8'h80, 8'h80);
		@(posedge clk);
		w(2'h0, 8'h80, 8'h05);
		rd_chk(2'h0, 8'h00, "unlock not restarted");
		w(2'h0, 8'h81, 8'h05);
		rd_chk(2'h0, 8'h00, "unlock refused");
		w(2'h0, 8'h80, 8'h7C);
		rd_chk(2'h0, 8'h0C, "reserved select");
		w(2'h0, 8'h03, 8'h03);
		rd_chk(2'h0, 8'h0C, "locked select");
	endtask : t_unlock
	task automatic t_div;
		int nc, ni;
		for (int s = 0; s <= 8; s++) begin
			w(2'h0, 8'h80, 8'(s));
			repeat (800) @(posedge clk);
			cnt(nc, ni, 512);
			`CHK("cpu rate", 512 >> s, nc)
			`CHK("io rate", 512 >> s, ni)
		end
		w(2'h0, 8'h80, 8'h00);
		repeat (700) @(posedge clk);
	endtask : t_div
	task automatic t_sleep(input logic [7:0] m, input logic [2:0] nw, input logic [2:0] src, input int mn,
		input logic eo, input int ei);
		int nc, ni, n;
		w(2'h1, m, m);
		nap();
		cnt(nc, ni, 8);
		`CHK("cpu gated", 0, nc)
		`CHK("io clock", ei, ni)
		`CHK("osc", eo, osc)
		wk <= nw;
		repeat (12) @(posedge clk);
		`CHK("stays halted", 1'b1, halted)
		wk <= src;
		n = 0;
		while (woke !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		if (n == 200) begin
			n_errors++;
			end_sim();
		end
		`CHK("wake delay", mn, n)
		@(posedge clk);
		wk <= 3'h0;
		repeat (4) @(posedge clk);
		rd_chk(2'h1, m, "sleep kept");
		w(2'h1, m & 8'h50, m & 8'h50);
	endtask : t_sleep
	initial begin
		t_rst(1'b0, 8'h00);
		t_unlock();
		t_div();
		w(2'h1, 8'h10, 8'h10);
		nap();
		`CHK("no sleep", 1'b0, halted)
		t_sleep(8'h20, 3'h0, 3'h1, 7, 1'b1, 8);
		t_sleep(8'h30, 3'h1, 3'h2, 29, 1'b0, 0);
		t_sleep(8'h70, 3'h1, 3'h4, 29, 1'b0, 0);
		t_sleep(8'h60, 3'h1, 3'h2, 29, 1'b0, 0);
		rd_chk(2'h2, 8'h11, "status no crystal");
		xtal <= 1'b1;
		t_sleep(8'h60, 3'h1, 3'h2, 15, 1'b1, 0);
		rd_chk(2'h2, 8'h12, "status standby");
		w(2'h1, 8'h30, 8'h30);
		nap();
		t_rst(1'b1, 8'h03);
		end_sim();
	end
endmodule : clock_prescaler_sleep_ctrl_tb

// >>> testbench/cps_assertions.sv
// Checker for the link between the core end and the controller end
`timescale 1ns/1ps
module cps_assertions
	import cps_pkg::*;
(
	// Clock, reset and link signals
	input wire logic       sys_clk_i,
	input wire logic       sys_rst_i,
	input wire logic [1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       sleep_instr,
	input wire logic       wake_irq,
	input wire logic       cpu_halted
);
	// ************************************************************
	// Sleep enable shadow, rebuilt from the writes on the link
	// ************************************************************
	logic se_r;
	logic se_nxt;
	always_comb se_nxt = (wr && addr == CPS_ADDR_SLEEP) ? wdata[CPS_SE_BIT] : se_r;
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			se_r <= 1'b0;
		else
			se_r <= se_nxt;
	end
	// ************************************************************
	// Properties
	// ************************************************************
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	read_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data outside its slot");
	div_zeros_a: assert property (rd && addr == CPS_ADDR_DIV |=> rdata[6:4] == 3'h0)
		else $error("divider bits 6 to 4 not zero");
	unlock_kept_a: assert property (!wr [*4] ##1 wr && addr == CPS_ADDR_DIV && wdata == CPS_UNLOCK_WORD
		##1 (!rd && (!wr || wdata == CPS_UNLOCK_WORD)) [*2] ##1 rd && addr == CPS_ADDR_DIV |=> rdata[7])
		else $error("unlock bit lost inside its window");
	sleep_enter_a: assert property (sleep_instr && se_r && !cpu_halted |=> cpu_halted)
		else $error("enabled sleep not entered");
	sleep_block_a: assert property (sleep_instr && !se_r && !cpu_halted |=> !cpu_halted)
		else $error("sleep entered without enable");
	halt_cause_a: assert property ($rose(cpu_halted) |-> $past(sleep_instr) && $past(se_r))
		else $error("halt without enabled sleep");
	halt_min_a: assert property ($rose(cpu_halted) |-> cpu_halted [*5])
		else $error("halt shorter than wake sequence");
	wake_pulse_a: assert property (wake_irq |=> !wake_irq)
		else $error("wake pulse longer than one cycle");
	wake_end_a: assert property ($fell(cpu_halted) |-> wake_irq)
		else $error("halt ended without wake pulse");
endmodule : cps_assertions
